// ### core/flt_defines.vh
// How it works
// R1 - low-res temperature mode: limit bit 7 reads zero and is ignored
// R2 - high-res limit is half-degree steps to 127.5; low-res whole degrees to 127
// R3 - temperature above entry-two limit drives fan duty from paired duty register
// R4 - compare uses 9 temperature bits in high-res, 8 bits in low-res
// R5 - limit is non-negative; temperature sign bit taken as zero
// R6 - table temperature offset register is added to the limit
// R7 - high-res duty joins upper two bits with lower six; low-res upper read zero
// R8 - extended duty bits act only while 22.5 kHz pwm frequency is selected
// R9 - low-res duty uses bits 5:0 of the duty register
// R10 - reset loads limit 0x7f and duty 0x3f
// R11 - hysteresis in 1 degree steps, max 31, reset 10, on falling temperature
// R12 - entry writes accepted only while table write enable is set
`ifndef FLT_DEFINES_VH
`define FLT_DEFINES_VH
`define FLT_ADDR_LIMIT    8'h52
`define FLT_ADDR_DUTY     8'h53
`define FLT_ADDR_OFFSET   8'h4e
`define FLT_ADDR_HYST     8'h4f
`define FLT_ADDR_CTRL     8'h4a
`define FLT_ADDR_STATUS   8'h70
`define FLT_RST_LIMIT     8'h7f
`define FLT_RST_DUTY      8'h3f
`define FLT_RST_OFFSET    8'h00
`define FLT_RST_HYST      5'h0a
`define FLT_RST_CTRL      8'h00
`define FLT_CTRL_WREN     5
`define FLT_CTRL_TEMP_HI  0
`define FLT_CTRL_DUTY_HI  1
`define FLT_CTRL_F22K5    2
`define FLT_HALF_BIT      7
`define FLT_EXT_MSB       7
`define FLT_EXT_LSB       6
`define FLT_BASE_MSB      5
`endif

// ### core/flt_compare.v
`timescale 1ns/1ps
`include "flt_defines.vh"
// temperature vs limit with hysteresis, all in half-degree units
module flt_compare (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [10:0] temp_i,
  input  wire [7:0]  limit_i,
  input  wire [7:0]  offset_i,
  input  wire [4:0]  hyst_i,
  input  wire        temp_hi_i,
  output reg         above_o
);
  reg  [10:0] temp_eff;
  reg  [10:0] lim_eff;
  wire [10:0] hyst_h = {5'h00, hyst_i, 1'b0}; // R11
  wire [10:0] lo_thr;
  always @* begin
    // temp_i: bit10 sign, [9:2] degrees, [1] half; sign dropped
    if (temp_hi_i)
      temp_eff = {2'b00, temp_i[9:2], temp_i[1]}; // R4 R5
    else
      temp_eff = {2'b00, temp_i[9:2], 1'b0}; // R4 R5
    if (temp_hi_i)
      lim_eff = {3'b000, limit_i}; // R2
    else
      lim_eff = {3'b000, limit_i[6:0], 1'b0}; // R1 R2
    lim_eff = lim_eff + {2'b00, offset_i, 1'b0}; // R6
  end
  assign lo_thr = (lim_eff > hyst_h) ? lim_eff - hyst_h : 11'h000;
  always @(posedge clk_i) begin
    if (rst_i)
      above_o <= 1'b0;
    else if (temp_eff > lim_eff)
      above_o <= 1'b1; // R3
    else if (temp_eff <= lo_thr)
      above_o <= 1'b0; // R11
  end
endmodule

// ### core/flt_entry2.v
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "flt_defines.vh"
// second table entry, wishbone classic slave, 8-bit data in low byte
module flt_entry2 (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [7:0]  adr_i,
  input  wire [31:0] dat_i,
  input  wire [3:0]  sel_i,
  input  wire        we_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg         err_o,
  input  wire [10:0] temp_i,
  output reg         fan_active_o,
  output reg  [7:0]  fan_duty_o
);
  reg  [7:0] limit_q;
  reg  [7:0] duty_q;
  reg  [7:0] offset_q;
  reg  [4:0] hyst_q;
  reg  [7:0] ctrl_q;
  wire       above;
  wire       req  = cyc_i & stb_i & ~ack_o & ~err_o;
  wire       wr   = req & we_i & sel_i[0];
  wire       wren = ctrl_q[`FLT_CTRL_WREN];
  wire       t_hi = ctrl_q[`FLT_CTRL_TEMP_HI];
  wire       d_hi = ctrl_q[`FLT_CTRL_DUTY_HI];
  wire       f22  = ctrl_q[`FLT_CTRL_F22K5];
  reg  [7:0] limit_rd;
  reg  [7:0] duty_rd;
  reg  [7:0] duty_eff;
  reg  [7:0] rd;
  reg        hit;

  always @* begin
    limit_rd = t_hi ? limit_q : {1'b0, limit_q[6:0]}; // R1
    duty_rd  = d_hi ? duty_q : {2'b00, duty_q[`FLT_BASE_MSB:0]}; // R7
    if (d_hi && f22)
      duty_eff = {duty_q[`FLT_EXT_MSB:`FLT_EXT_LSB],
                  duty_q[`FLT_BASE_MSB:0]}; // R7 R8
    else
      duty_eff = {2'b00, duty_q[`FLT_BASE_MSB:0]}; // R9
  end

  always @* begin
    hit = 1'b1;
    rd  = 8'h00;
    case (adr_i)
      `FLT_ADDR_LIMIT:  rd = limit_rd;
      `FLT_ADDR_DUTY:   rd = duty_rd;
      `FLT_ADDR_OFFSET: rd = offset_q;
      `FLT_ADDR_HYST:   rd = {3'b000, hyst_q};
      `FLT_ADDR_CTRL:   rd = ctrl_q;
      `FLT_ADDR_STATUS: rd = {7'h00, fan_active_o};
      default:          hit = 1'b0;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      limit_q  <= `FLT_RST_LIMIT; // R10
      duty_q   <= `FLT_RST_DUTY; // R10
      offset_q <= `FLT_RST_OFFSET;
      hyst_q   <= `FLT_RST_HYST; // R11
      ctrl_q   <= `FLT_RST_CTRL;
      ack_o    <= 1'b0;
      err_o    <= 1'b0;
      dat_o    <= 32'h0000_0000;
    end else begin
      ack_o <= req & hit;
      err_o <= req & ~hit;
      dat_o <= (req & hit & ~we_i) ? {24'h000000, rd} : 32'h0000_0000;
      if (wr && hit) begin
        case (adr_i)
          `FLT_ADDR_LIMIT:
            if (wren)
              limit_q <= t_hi ? dat_i[7:0]
                              : {1'b0, dat_i[6:0]}; // R12 R1
          `FLT_ADDR_DUTY:
            if (wren)
              duty_q <= d_hi ? dat_i[7:0]
                             : {2'b00, dat_i[5:0]}; // R12 R7
          `FLT_ADDR_OFFSET: offset_q <= dat_i[7:0];
          `FLT_ADDR_HYST:   hyst_q <= dat_i[4:0]; // R11
          `FLT_ADDR_CTRL:   ctrl_q <= dat_i[7:0];
          default:          ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  flt_compare u_cmp (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .temp_i    (temp_i),
    .limit_i   (limit_q),
    .offset_i  (offset_q),
    .hyst_i    (hyst_q),
    .temp_hi_i (t_hi),
    .above_o   (above)
  );

  // one cycle after the compare flop so outputs stay registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      fan_active_o <= 1'b0;
      fan_duty_o   <= 8'h00;
    end else begin
      fan_active_o <= above;
      fan_duty_o   <= above ? duty_eff : 8'h00; // R3
    end
  end
endmodule

// ### verif/flt_sva.sv
`timescale 1ns/1ps
module flt_sva (
  input wire        clk_i,
  input wire        rst_i,
  input wire [7:0]  adr_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire        err_o,
  input wire        fan_active_o,
  input wire [7:0]  fan_duty_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; cyc_i && stb_i && !ack_o && !err_o; endsequence
  property p_ans; s_req |=> ack_o != err_o; endproperty
  property p_one; ack_o |=> !ack_o && !err_o; endproperty
  property p_zero; !ack_o |-> dat_o == 32'h0; endproperty
  property p_hi; dat_o[31:8] == 24'h0; endproperty
  property p_map; s_req and adr_i[7:1] == 7'h29 |=> ack_o; endproperty
  property p_bad; s_req and adr_i == 8'h50 |=> err_o; endproperty
  property p_off; !fan_active_o |-> fan_duty_o == 8'h0; endproperty
  property p_rst; $fell(rst_i) |-> !fan_active_o; endproperty
  a_ans: assert property (p_ans) else $error("bad answer");
  a_one: assert property (p_one) else $error("long ack");
  a_zero: assert property (p_zero) else $error("data off ack");
  a_hi: assert property (p_hi) else $error("upper data");
  a_map: assert property (p_map) else $error("no ack");
  a_bad: assert property (p_bad) else $error("no err");
  a_off: assert property (p_off) else $error("duty idle");
  a_rst: assert property (p_rst) else $error("fan rst");
endmodule
bind flt_entry2 flt_sva u_sva (
  .clk_i        (clk_i),
  .rst_i        (rst_i),
  .adr_i        (adr_i),
  .cyc_i        (cyc_i),
  .stb_i        (stb_i),
  .dat_o        (dat_o),
  .ack_o        (ack_o),
  .err_o        (err_o),
  .fan_active_o (fan_active_o),
  .fan_duty_o   (fan_duty_o)
);

// ### verif/tb_flt_entry2.sv
`timescale 1ns/1ps
module tb_flt_entry2;
  logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, er;
  logic [7:0]  adr_i = 8'h0, rd;
  logic [31:0] dat_i = 32'h0;
  logic [3:0]  sel_i = 4'h1;
  logic [10:0] temp_i = 11'h0;
  wire  [31:0] dat_o;
  wire         ack_o, err_o, fan_active_o;
  wire  [7:0]  fan_duty_o;
  int          error_cnt = 0, total_checks = 0;
  always #50 clk_i = ~clk_i;
  flt_entry2 dut_u (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .adr_i        (adr_i),
    .dat_i        (dat_i),
    .sel_i        (sel_i),
    .we_i         (we_i),
    .cyc_i        (cyc_i),
    .stb_i        (stb_i),
    .dat_o        (dat_o),
    .ack_o        (ack_o),
    .err_o        (err_o),
    .temp_i       (temp_i),
    .fan_active_o (fan_active_o),
    .fan_duty_o   (fan_duty_o)
  );
  task give_verdict;
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task ck(input string s, input [7:0] e, input [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task wb(input [7:0] a, input w, input [7:0] d);
    int n;
    n = 0;
    adr_i <= a;
    we_i <= w;
    dat_i <= {24'h0, d};
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 9);
    rd = dat_o[7:0];
    er = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 9) begin
      error_cnt++;
      give_verdict;
    end
    @(posedge clk_i);
  endtask
  // fan path lags two edges; third edge lets it settle
  task tp(input s, input [7:0] d, input h, input a, input [7:0] u);
    temp_i <= {s, d, h, 1'b0};
    repeat (3) @(posedge clk_i);
    ck("active", {7'h0, a}, {7'h0, fan_active_o});
    ck("duty", u, fan_duty_o);
  endtask
  task t_rst;
    wb(8'h52, 0, 8'h0);
    ck("limit", 8'h7f, rd);
    wb(8'h53, 0, 8'h0);
    ck("duty reg", 8'h3f, rd);
  endtask
  task t_lock;
    wb(8'h52, 1, 8'h0);
    wb(8'h52, 0, 8'h0);
    ck("locked", 8'h7f, rd);
    wb(8'h50, 0, 8'h0);
    ck("err", 8'h1, {7'h0, er});
  endtask
  task t_low;
    wb(8'h4a, 1, 8'h20);
    wb(8'h52, 1, 8'ha0);
    wb(8'h52, 0, 8'h0);
    ck("limit lo", 8'h20, rd);
    wb(8'h53, 1, 8'hff);
    wb(8'h53, 0, 8'h0);
    ck("duty lo", 8'h3f, rd);
    tp(0, 8'h20, 1, 0, 8'h0);
    tp(1, 8'h21, 0, 1, 8'h3f);
    tp(0, 8'h17, 0, 1, 8'h3f);
    tp(0, 8'h16, 0, 0, 8'h0);
  endtask
  task t_high;
    wb(8'h4a, 1, 8'h27);
    wb(8'h52, 1, 8'h81);
    wb(8'h53, 1, 8'hff);
    tp(0, 8'h40, 1, 0, 8'h0);
    tp(0, 8'h41, 0, 1, 8'hff);
    wb(8'h4a, 1, 8'h23);
    tp(0, 8'h41, 0, 1, 8'h3f);
    wb(8'h4e, 1, 8'h10);
    tp(0, 8'h41, 0, 0, 8'h0);
    tp(0, 8'h51, 0, 1, 8'h3f);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_rst;
    t_lock;
    t_low;
    t_high;
    give_verdict;
  end
endmodule
